// ==== logic/timer8_pkg.sv ====
// Constants, codes and decode helpers shared by the timer core files
package timer8_pkg;

  // Register bus shape
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [2:0] OFS_COUNTER = 3'h0;
  localparam logic [2:0] OFS_COMPARE_A = 3'h1;
  localparam logic [2:0] OFS_COMPARE_B = 3'h2;
  localparam logic [2:0] OFS_CONTROL_A = 3'h3;
  localparam logic [2:0] OFS_CONTROL_B = 3'h4;
  localparam logic [2:0] OFS_FLAGS = 3'h5;
  localparam logic [2:0] OFS_MASK = 3'h6;

  // Field positions in timer_control_a
  localparam int CTLA_ACT_A_LSB = 6;
  localparam int CTLA_ACT_B_LSB = 4;
  localparam int CTLA_MODE_LSB = 0;

  // Field positions in timer_control_b
  localparam int CTLB_FORCE_A = 7;
  localparam int CTLB_FORCE_B = 6;
  localparam int CTLB_MODE2 = 3;
  localparam int CTLB_TICK_LSB = 0;

  // Bit positions in flag and mask registers
  localparam int FLAG_OVF = 0;
  localparam int FLAG_MATCH_A = 1;
  localparam int FLAG_MATCH_B = 2;

  // Reset values and counter limits
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BOTTOM = 8'h00;
  localparam logic [7:0] MAX = 8'hff;
  localparam logic [7:0] ONE = 8'h01;

  // Waveform mode codes
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PC_MAX = 3'h1;
  localparam logic [2:0] MODE_CTC = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_A = 3'h5;
  localparam logic [2:0] MODE_FAST_A = 3'h7;

  // Tick source codes
  localparam logic [2:0] TICK_OFF = 3'h0;

  // Compare output action codes
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // Count direction, used by the dual-slope sequence
  typedef enum logic {DIR_UP, DIR_DOWN} count_dir_t;

  // Single-slope PWM modes
  function automatic logic is_fast(input logic [2:0] mode);
    is_fast = (mode == MODE_FAST_MAX) || (mode == MODE_FAST_A);
  endfunction : is_fast

  // Dual-slope PWM modes
  function automatic logic is_phase(input logic [2:0] mode);
    is_phase = (mode == MODE_PC_MAX) || (mode == MODE_PC_A);
  endfunction : is_phase

endpackage : timer8_pkg

// ==== logic/compare_channel.sv ====
// One output compare unit: compare buffer, active value, match and output latch
`timescale 1ns/10ps
`default_nettype none

module compare_channel (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Software access
  input wire logic sw_write,
  input wire logic [7:0] sw_data,
  // Counter side
  input wire logic tick,
  input wire logic [7:0] counter,
  input wire logic block,
  input wire logic buffered,
  input wire logic reload,
  input wire logic force_strobe,
  // Waveform control
  input wire logic [1:0] action,
  input wire logic fast_pwm,
  input wire logic phase_pwm,
  input wire logic count_down,
  input wire logic wrap_bottom,
  input wire logic toggle_ok,
  // Results
  output logic [7:0] active_value,
  output logic [7:0] buffer_value,
  output logic match_event,
  output logic out_latch
);
  import timer8_pkg::*;

  logic [7:0] active_next;
  logic [7:0] buffer_next;
  logic latch_next;
  logic hit;
  logic pwm;
  logic match_level;
  logic do_toggle;

  // Equality is checked every cycle, but only acts on a tick
  assign match_event = tick && (counter == active_value) && !block;
  assign hit = match_event || force_strobe;
  assign pwm = fast_pwm || phase_pwm;

  // Buffer catches every write; active takes it directly only when unbuffered
  assign buffer_next = sw_write ? sw_data : buffer_value;
  assign active_next = (sw_write && !buffered) ? sw_data :
                       (reload && buffered) ? buffer_value : active_value;

  // Down-count in dual slope inverts the level driven on a match
  assign match_level = (phase_pwm && count_down) ? (action == ACT_CLEAR) : (action == ACT_SET);
  assign do_toggle = (action == ACT_TOGGLE) && (!pwm || toggle_ok);

  // Action is read live, so a new setting hits at the very next match
  assign latch_next = (hit && action[1]) ? match_level :
                      (hit && do_toggle) ? !out_latch :
                      (fast_pwm && wrap_bottom && action[1]) ? (action == ACT_CLEAR) :
                      out_latch;

  // Latch survives mode changes; it changes only on reset, a match, a force or a fast PWM wrap
  always_ff @(posedge clk) begin
    if (reset) begin
      active_value <= RST_BYTE;
      buffer_value <= RST_BYTE;
      out_latch <= 1'b0;
    end else if (clk_en) begin
      active_value <= active_next;
      buffer_value <= buffer_next;
      out_latch <= latch_next;
    end
  end

endmodule : compare_channel

`default_nettype wire

// ==== logic/timer8_counter_compare_core.sv ====
// 8-bit timer/counter with two compare units, flags and pin override
//
// What this block does
// - Three-bit tick select chooses tick source; zero means stopped counter.
// - Each tick clears, increments or decrements counter per waveform mode.
// - Software reads and writes counter whether or not ticks arrive.
// - Software counter write beats any count or clear that cycle.
// - Waveform mode is three bits: two in control A, one in B.
// - Counter compared each cycle; equality sets match flag at next tick.
// - Match flag clears on service acknowledge or on writing one.
// - Compare values double buffered in PWM modes, direct otherwise.
// - Buffered compare value moves to active only at top, never at bottom.
// - Compare access hits buffer when buffered, active value when not.
// - Force strobe acts like a match on latch only, non-PWM modes.
// - Counter write blocks all compare matches on the next tick.
// - Compare output latches keep their value across mode changes.
// - Output action bits are live; new setting acts at next match.
// - Reset clears both compare output latches to zero.
// - Nonzero action puts latch on pin; direction stays with port.
// - Action zero leaves latch unchanged on match in every mode.
// - Only the waveform mode field shapes the count sequence.
// - Normal mode counts up only, wrapping from 0xff to 0x00.
// - Normal mode sets overflow flag on the tick counter becomes zero.
// - Bottom is 0x00, maximum 0xff, top is maximum or compare A.
// - Overflow and match flags readable, each with its own mask bit.
`timescale 1ns/10ps
`default_nettype none

module timer8_counter_compare_core (
  // Clock, reset and freeze
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [timer8_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer8_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [timer8_pkg::DATA_W-1:0] reg_rdata,
  // Tick sources
  input wire logic [3:0] prescale_tick,
  input wire logic ext_tick_pin,
  // Interrupt handshake, bit order overflow, match a, match b
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  // Port pins for compare outputs a and b
  input wire logic [1:0] port_value,
  input wire logic [1:0] port_dir,
  output logic [1:0] cmp_pin_out,
  output logic [1:0] cmp_pin_oe
);
  import timer8_pkg::*;

  // Software visible state
  logic [7:0] counter_value_reg;
  logic [7:0] counter_value_next;
  logic [7:0] control_a_reg;
  logic [7:0] control_b_reg;
  logic [2:0] flag_reg;
  logic [2:0] flag_next;
  logic [2:0] mask_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Internal sequencing state
  count_dir_t dir_reg;
  count_dir_t dir_next;
  logic block_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;

  // Decoded control fields
  logic [2:0] waveform_mode_field;
  logic [2:0] tick_source_select;
  logic [1:0] compare_output_action [2];
  logic [1:0] force_compare_strobe;
  logic fast_pwm;
  logic phase_pwm;
  logic buffered;
  logic top_is_a;

  // Tick selection
  logic [7:0] tick_options;
  logic timer_tick;
  logic ext_rise;
  logic ext_fall;

  // Counter decode
  logic [7:0] top_value;
  logic at_top;
  logic at_bottom;
  logic at_max;
  logic [7:0] count_up;
  logic [7:0] count_down;
  logic [7:0] seq_next;
  logic overflow_set;
  logic reload;
  logic wrap_bottom;

  // Bus decode
  logic wr_counter;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_ctl_a;
  logic wr_ctl_b;
  logic wr_flags;
  logic wr_mask;
  logic [2:0] flag_set;
  logic [2:0] flag_clear;

  // Compare unit results
  logic [7:0] active_value [2];
  logic [7:0] buffer_value [2];
  logic [1:0] match_event;
  logic [1:0] compare_output_latch;
  logic [1:0] cmp_write;
  logic [1:0] toggle_ok;
  logic [7:0] compare_read [2];

  // Field extraction; the mode spans two registers
  // Modes 4 and 6 match none of the decodes below, so they count like Normal mode
  assign waveform_mode_field = {control_b_reg[CTLB_MODE2],
                                control_a_reg[CTLA_MODE_LSB +: 2]};
  assign tick_source_select = control_b_reg[CTLB_TICK_LSB +: 3];
  assign compare_output_action[0] = control_a_reg[CTLA_ACT_A_LSB +: 2];
  assign compare_output_action[1] = control_a_reg[CTLA_ACT_B_LSB +: 2];
  assign fast_pwm = is_fast(waveform_mode_field);
  assign phase_pwm = is_phase(waveform_mode_field);
  assign buffered = fast_pwm || phase_pwm;
  assign top_is_a = (waveform_mode_field == MODE_CTC) ||
                    (waveform_mode_field == MODE_PC_A) ||
                    (waveform_mode_field == MODE_FAST_A);

  // Register write decode
  // A write to the unused offset falls through every decode and is dropped
  assign wr_counter = reg_write && (reg_addr == OFS_COUNTER);
  assign wr_cmp_a = reg_write && (reg_addr == OFS_COMPARE_A);
  assign wr_cmp_b = reg_write && (reg_addr == OFS_COMPARE_B);
  assign wr_ctl_a = reg_write && (reg_addr == OFS_CONTROL_A);
  assign wr_ctl_b = reg_write && (reg_addr == OFS_CONTROL_B);
  assign wr_flags = reg_write && (reg_addr == OFS_FLAGS);
  assign wr_mask = reg_write && (reg_addr == OFS_MASK);
  assign cmp_write = {wr_cmp_b, wr_cmp_a};

  // Force strobes live only in the write cycle and never in PWM modes
  assign force_compare_strobe[0] = wr_ctl_b && reg_wdata[CTLB_FORCE_A] && !buffered;
  assign force_compare_strobe[1] = wr_ctl_b && reg_wdata[CTLB_FORCE_B] && !buffered;

  // Toggle in PWM modes is only offered on unit a with top at compare a
  assign toggle_ok = {1'b0, waveform_mode_field[2]};

  // External edge detect looks only at the second sync stage
  assign ext_rise = ext_sync2_reg && !ext_prev_reg;
  assign ext_fall = !ext_sync2_reg && ext_prev_reg;

  // Select list, index is the tick select code; code zero is a dead source
  // Prescaler pulses come from this clock, so only the pin needs a synchroniser
  assign tick_options = {ext_rise, ext_fall, prescale_tick, 1'b1, 1'b0};
  assign timer_tick = clk_en && (tick_source_select != TICK_OFF) &&
                      tick_options[tick_source_select];

  // Sequence limits
  // Top follows the active value, so a buffered update can only move it at top
  assign top_value = top_is_a ? active_value[0] : MAX;
  assign at_top = (counter_value_reg == top_value);
  assign at_bottom = (counter_value_reg == BOTTOM);
  assign at_max = (counter_value_reg == MAX);
  assign count_up = counter_value_reg + ONE;
  assign count_down = counter_value_reg - ONE;

  // Only the waveform mode steers the sequence; action bits never do
  always_comb begin
    seq_next = count_up;
    dir_next = DIR_UP;
    unique case (1'b1)
      phase_pwm: begin
        if (dir_reg == DIR_UP) begin
          dir_next = at_top ? DIR_DOWN : DIR_UP;
          seq_next = at_top ? count_down : count_up;
        end else begin
          dir_next = at_bottom ? DIR_UP : DIR_DOWN;
          seq_next = at_bottom ? count_up : count_down;
        end
      end
      fast_pwm, (waveform_mode_field == MODE_CTC): begin
        seq_next = at_top ? BOTTOM : count_up;
      end
      default: begin
        seq_next = count_up;
      end
    endcase
  end

  // Software write wins over the tick in the same cycle
  assign counter_value_next = wr_counter ? reg_wdata :
                              timer_tick ? seq_next : counter_value_reg;

  // Overflow point depends on the sequence shape
  // Dual slope sets it only on the bottom turn, never on the way up from a write
  assign overflow_set = timer_tick && !wr_counter &&
                        (phase_pwm ? (at_bottom && dir_reg == DIR_DOWN) :
                         fast_pwm ? at_top : at_max);

  // Buffered values load at top, where the slope turns or restarts
  assign reload = timer_tick && buffered && at_top;
  assign wrap_bottom = timer_tick && fast_pwm && at_top && !wr_counter;

  // Flag update: hardware set wins over a clear in the same cycle
  // Otherwise a late acknowledge could swallow an event that landed on the same edge
  assign flag_set = {match_event[1], match_event[0], overflow_set};
  assign flag_clear = (wr_flags ? reg_wdata[2:0] : 3'h0) | irq_ack;
  assign flag_next = flag_set | (flag_reg & ~flag_clear);

  // Request is a plain gate, so clearing a flag drops it next cycle
  assign irq_req = flag_reg & mask_reg;

  // Compare reads follow the buffer when buffering is on
  // The active value of a buffered unit is therefore hidden from software
  assign compare_read[0] = buffered ? buffer_value[0] : active_value[0];
  assign compare_read[1] = buffered ? buffer_value[1] : active_value[1];

  // Read data multiplexer; unmapped offsets and strobe bits read zero
  always_comb begin
    rdata_next = RST_BYTE;
    if (reg_read) begin
      unique case (reg_addr)
        OFS_COUNTER: rdata_next = counter_value_reg;
        OFS_COMPARE_A: rdata_next = compare_read[0];
        OFS_COMPARE_B: rdata_next = compare_read[1];
        OFS_CONTROL_A: rdata_next = control_a_reg;
        OFS_CONTROL_B: rdata_next = {2'h0, control_b_reg[5:0]};
        OFS_FLAGS: rdata_next = {5'h0, flag_reg};
        OFS_MASK: rdata_next = {5'h0, mask_reg};
        default: rdata_next = RST_BYTE;
      endcase
    end
  end

  // Two compare units share all counter-side signals except the force strobe
  // Unit a also feeds top in the modes whose top follows compare a
  genvar u;
  generate
    for (u = 0; u < 2; u++) begin : g_unit
      compare_channel unit (
        .clk(clk),
        .reset(reset),
        .clk_en(clk_en),
        .sw_write(cmp_write[u]),
        .sw_data(reg_wdata),
        .tick(timer_tick),
        .counter(counter_value_reg),
        .block(block_reg),
        .buffered(buffered),
        .reload(reload),
        .force_strobe(force_compare_strobe[u]),
        .action(compare_output_action[u]),
        .fast_pwm(fast_pwm),
        .phase_pwm(phase_pwm),
        .count_down(dir_reg == DIR_DOWN),
        .wrap_bottom(wrap_bottom),
        .toggle_ok(toggle_ok[u]),
        .active_value(active_value[u]),
        .buffer_value(buffer_value[u]),
        .match_event(match_event[u]),
        .out_latch(compare_output_latch[u])
      );
      // Override is mode independent; direction always comes from the port
      assign cmp_pin_out[u] = (compare_output_action[u] != ACT_NONE) ?
                              compare_output_latch[u] : port_value[u];
      assign cmp_pin_oe[u] = port_dir[u];
    end
  endgenerate

  // External tick pin crosses in through two stages
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else if (clk_en) begin
      ext_sync1_reg <= ext_tick_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end

  // Counter and direction
  // A software write keeps the direction, so a dual-slope run resumes its slope
  always_ff @(posedge clk) begin
    if (reset) begin
      counter_value_reg <= RST_BYTE;
      dir_reg <= DIR_UP;
    end else if (clk_en) begin
      counter_value_reg <= counter_value_next;
      dir_reg <= wr_counter ? dir_reg : (timer_tick ? dir_next : dir_reg);
    end
  end

  // Block is held until the next tick, so it also covers a stopped timer
  // A write while stopped thus stays armed until ticks resume, however long that is
  always_ff @(posedge clk) begin
    if (reset) begin
      block_reg <= 1'b0;
    end else if (clk_en) begin
      block_reg <= wr_counter || (block_reg && !timer_tick);
    end
  end

  // Control, mask and flag registers
  always_ff @(posedge clk) begin
    if (reset) begin
      control_a_reg <= RST_BYTE;
      control_b_reg <= RST_BYTE;
      mask_reg <= 3'h0;
      flag_reg <= 3'h0;
    end else if (clk_en) begin
      control_a_reg <= wr_ctl_a ? reg_wdata : control_a_reg;
      control_b_reg <= wr_ctl_b ? {2'h0, reg_wdata[5:0]} : control_b_reg;
      mask_reg <= wr_mask ? reg_wdata[2:0] : mask_reg;
      flag_reg <= flag_next;
    end
  end

  // Read data stands for exactly the cycle after the strobe
  // Freezing the clock enable also freezes read data, so a read then stalls too
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= RST_BYTE;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule : timer8_counter_compare_core

`default_nettype wire

// ==== verif/timer8_core_sva.sv ====
// Port-level assertions for the timer core
`timescale 1ns/10ps
`default_nettype none

module timer8_core_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port
  input wire logic [timer8_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [timer8_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [timer8_pkg::DATA_W-1:0] reg_rdata,
  // Interrupts and pins
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq_req,
  input wire logic [1:0] port_value,
  input wire logic [1:0] port_dir,
  input wire logic [1:0] cmp_pin_out,
  input wire logic [1:0] cmp_pin_oe
);
  import timer8_pkg::*;
  logic [2:0] mask_q;
  logic [3:0] act_q;
  logic armed_q = 1'b0;
  // Write decodes seen from the bus side
  wire logic mask_wr = reg_write && clk_en && (reg_addr == OFS_MASK);
  wire logic ctla_wr = reg_write && clk_en && (reg_addr == OFS_CONTROL_A);
  wire logic clr_wr = reg_write && (reg_addr == OFS_FLAGS || reg_addr == OFS_MASK);

  // Shadows of mask and action bits; the pins and irqs can only be judged against them
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_q <= 3'h0;
      act_q <= 4'h0;
      armed_q <= 1'b1;
    end else begin
      if (mask_wr) mask_q <= reg_wdata[2:0];
      if (ctla_wr) act_q <= reg_wdata[7:4];
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Pin direction, pin source and request masking
  pin_dir_a: assert property (cmp_pin_oe == port_dir)
    else $error("pin enable differs from port direction");
  pin_port_a: assert property (
    (act_q[3:2] != ACT_NONE || cmp_pin_out[0] == port_value[0]) &&
    (act_q[1:0] != ACT_NONE || cmp_pin_out[1] == port_value[1]))
    else $error("idle action pin not from port");
  irq_masked_a: assert property ((irq_req & ~mask_q) == 3'h0)
    else $error("request raised without mask");
  mask_read_a: assert property (
    $past(reg_read && reg_addr == OFS_MASK) |-> reg_rdata[2:0] == mask_q)
    else $error("mask readback wrong");
  // Read data only in the cycle after a read
  rdata_idle_a: assert property ($past(clk_en) && !$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  force_read_a: assert property (
    $past(reg_read && reg_addr == OFS_CONTROL_B) |-> reg_rdata[7:6] == 2'h0)
    else $error("force strobe reads back");
  // Flags drop only through acknowledge, write or mask
  match_clr_a: assert property ($fell(irq_req[1]) |-> $past(irq_ack[1]) || $past(clr_wr))
    else $error("match request dropped without cause");
  ovf_clr_a: assert property ($fell(irq_req[0]) |-> $past(irq_ack[0]) || $past(clr_wr))
    else $error("overflow request dropped without cause");
  rst_clear_a: assert property (disable iff (1'b0) armed_q && $past(reset) |->
    irq_req == 3'h0 && reg_rdata == RST_BYTE && cmp_pin_out == port_value)
    else $error("state not cleared by reset");

  cover property (irq_req[0]);
  cover property (irq_req[1]);
  cover property (irq_req[2]);
endmodule : timer8_core_sva

bind timer8_counter_compare_core timer8_core_sva sva (
  .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq_ack(irq_ack),
  .irq_req(irq_req), .port_value(port_value), .port_dir(port_dir), .cmp_pin_out(cmp_pin_out),
  .cmp_pin_oe(cmp_pin_oe)
);

`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking bench for the timer core
`timescale 1ns/10ps
`default_nettype none

module tb;
  import timer8_pkg::*;
  logic clk;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] prescale_tick = 4'h0;
  logic ext_tick_pin = 1'b0;
  logic [2:0] irq_ack = 3'h0;
  logic [2:0] irq_req;
  logic [1:0] port_value = 2'h1;
  logic [1:0] port_dir = 2'h3;
  logic [1:0] cmp_pin_out;
  logic [1:0] cmp_pin_oe;
  logic [7:0] rd_q;
  int miscompares = 0;
  int checks_done = 0;

  timer8_counter_compare_core dut (
    .clk(clk), .reset(reset), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .prescale_tick(prescale_tick), .ext_tick_pin(ext_tick_pin), .irq_ack(irq_ack),
    .irq_req(irq_req), .port_value(port_value), .port_dir(port_dir),
    .cmp_pin_out(cmp_pin_out), .cmp_pin_oe(cmp_pin_oe)
  );

  // Clock at 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic test_done();
    if (miscompares == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One write, optionally with a tick pulse on the same edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic tk);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    prescale_tick <= {3'h0, tk};
    @(posedge clk);
    reg_write <= 1'b0;
    prescale_tick <= 4'h0;
    #1;
  endtask : wr

  // Read data is taken in the one cycle it stands
  task automatic rd(input logic [2:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask : rd

  // Ticks on select code 2, one idle cycle between pulses
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      prescale_tick <= 4'h1;
      @(posedge clk);
      prescale_tick <= 4'h0;
    end
    #1;
  endtask : tick

  task automatic ack(input logic [2:0] b);
    @(posedge clk);
    irq_ack <= b;
    @(posedge clk);
    irq_ack <= 3'h0;
    #1;
  endtask : ack

  task automatic t_reset();
    wr(3'h7, 8'h5a, 1'b0);
    for (int a = 0; a < 8; a++) begin
      rd(a[2:0]);
      chk("reset register", rd_q, RST_BYTE);
    end
    chk("pin after reset", {6'h0, cmp_pin_out}, 8'h01);
  endtask : t_reset

  task automatic t_count();
    wr(OFS_CONTROL_B, {5'h0, TICK_OFF}, 1'b0);
    wr(OFS_COUNTER, 8'h10, 1'b0);
    tick(3);
    rd(OFS_COUNTER);
    chk("stopped counter", rd_q, 8'h10);
    wr(OFS_CONTROL_B, 8'h02, 1'b0);
    tick(2);
    rd(OFS_COUNTER);
    chk("counting", rd_q, 8'h12);
    wr(OFS_COUNTER, 8'h40, 1'b1);
    rd(OFS_COUNTER);
    chk("write over tick", rd_q, 8'h40);
  endtask : t_count

  task automatic t_overflow();
    wr(OFS_MASK, 8'h07, 1'b0);
    wr(OFS_COUNTER, 8'hfe, 1'b0);
    tick(1);
    chk("early overflow", {5'h0, irq_req}, 8'h00);
    tick(1);
    chk("overflow irq", {5'h0, irq_req}, 8'h01);
    rd(OFS_COUNTER);
    chk("wrap", rd_q, BOTTOM);
    rd(OFS_FLAGS);
    chk("overflow flag", rd_q, 8'h01);
    wr(OFS_FLAGS, 8'h01, 1'b0);
    chk("write one clear", {5'h0, irq_req}, 8'h00);
    wr(OFS_COUNTER, 8'hfe, 1'b0);
    tick(2);
    ack(3'h1);
    chk("ack clear", {5'h0, irq_req}, 8'h00);
  endtask : t_overflow

  // Counter write while stopped still blocks the first match
  task automatic t_match();
    wr(OFS_COMPARE_A, 8'h05, 1'b0);
    wr(OFS_CONTROL_B, {5'h0, TICK_OFF}, 1'b0);
    wr(OFS_COUNTER, 8'h05, 1'b0);
    wr(OFS_CONTROL_B, 8'h02, 1'b0);
    tick(1);
    chk("blocked match", {5'h0, irq_req}, 8'h00);
    wr(OFS_COUNTER, 8'h04, 1'b0);
    tick(2);
    chk("match irq", {5'h0, irq_req}, 8'h02);
    rd(OFS_COMPARE_A);
    chk("direct compare", rd_q, 8'h05);
    ack(3'h2);
    chk("match ack", {5'h0, irq_req}, 8'h00);
  endtask : t_match

  task automatic t_pins();
    wr(OFS_CONTROL_A, {ACT_SET, ACT_NONE, 4'h0}, 1'b0);
    chk("latch reset", {6'h0, cmp_pin_out}, 8'h00);
    chk("pin enable", {6'h0, cmp_pin_oe}, 8'h03);
    wr(OFS_CONTROL_B, 8'h82, 1'b0);
    chk("forced set", {6'h0, cmp_pin_out}, 8'h01);
    chk("force flag", {5'h0, irq_req}, 8'h00);
    rd(OFS_COUNTER);
    chk("force counter", rd_q, 8'h06);
    wr(OFS_CONTROL_A, {ACT_TOGGLE, ACT_NONE, 4'h0}, 1'b0);
    wr(OFS_CONTROL_B, 8'h82, 1'b0);
    chk("forced toggle", {6'h0, cmp_pin_out}, 8'h00);
    wr(OFS_CONTROL_A, {ACT_NONE, ACT_NONE, 4'h0}, 1'b0);
    wr(OFS_CONTROL_B, 8'h82, 1'b0);
    wr(OFS_CONTROL_A, {ACT_SET, ACT_NONE, 4'h0}, 1'b0);
    chk("idle action hold", {6'h0, cmp_pin_out}, 8'h00);
    @(posedge clk);
    port_value <= 2'h2;
    #1 chk("port b passes", {6'h0, cmp_pin_out}, 8'h02);
    wr(OFS_COUNTER, 8'h03, 1'b0);
    tick(3);
    chk("match sets latch", {6'h0, cmp_pin_out}, 8'h03);
    wr(OFS_CONTROL_A, {ACT_SET, ACT_NONE, 2'h0, MODE_FAST_MAX[1:0]}, 1'b0);
    chk("latch over mode", {6'h0, cmp_pin_out}, 8'h03);
  endtask : t_pins

  // Fast PWM: compare b waits in its buffer until top
  task automatic t_buffer();
    wr(OFS_COMPARE_B, 8'h07, 1'b0);
    rd(OFS_COMPARE_B);
    chk("buffer read", rd_q, 8'h07);
    wr(OFS_COUNTER, 8'h06, 1'b0);
    tick(2);
    chk("old active", {7'h0, irq_req[2]}, 8'h00);
    wr(OFS_COUNTER, 8'hfd, 1'b0);
    tick(11);
    chk("reload at top", {7'h0, irq_req[2]}, 8'h01);
  endtask : t_buffer

  // Clear on match fed by rising pin edges, then a dual-slope turn at top
  task automatic t_modes();
    wr(OFS_CONTROL_A, {6'h0, MODE_CTC[1:0]}, 1'b0);
    wr(OFS_CONTROL_B, 8'h07, 1'b0);
    wr(OFS_COUNTER, 8'h04, 1'b0);
    repeat (3) begin
      @(posedge clk);
      ext_tick_pin <= 1'b1;
      repeat (4) @(posedge clk);
      ext_tick_pin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rd(OFS_COUNTER);
    chk("clear at top", rd_q, 8'h01);
    wr(OFS_CONTROL_B, {5'h01, TICK_OFF}, 1'b0);
    wr(OFS_CONTROL_A, {6'h0, MODE_PC_A[1:0]}, 1'b0);
    wr(OFS_COUNTER, 8'h03, 1'b0);
    wr(OFS_CONTROL_B, 8'h0a, 1'b0);
    tick(4);
    rd(OFS_COUNTER);
    chk("turn at top", rd_q, 8'h03);
  endtask : t_modes

  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_count();
    t_overflow();
    t_match();
    t_pins();
    t_buffer();
    t_modes();
    test_done();
  end

  // Watchdog against a hang
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule : tb

`default_nettype wire
